// *** hw/usb_host_status_frame_timer.sv ***
`timescale 1ns/1ns
module usb_host_status_frame_timer
  import usb_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Local processor access
  input  wire logic [15:0] cpuAddr,
  input  wire logic        cpuWr,
  input  wire logic        cpuRd,
  input  wire logic [15:0] cpuWdata,
  output logic      [15:0] cpuRdata,
  output logic             cpuAck,
  // Parallel host access port
  input  wire logic [15:0] hpiAddr,
  input  wire logic        hpiWr,
  input  wire logic        hpiRd,
  input  wire logic [15:0] hpiWdata,
  output logic      [15:0] hpiRdata,
  output logic             hpiAck,
  // OTG and line pins
  input  wire logic        vbusValid,
  input  wire logic        otgId,
  input  wire logic [3:0]  se0Line,
  // Events from the serial engines
  input  wire logic [3:0]  remoteWake,
  input  wire logic [1:0]  transferDone,
  // Outputs
  output logic      [1:0]  hostIrq,
  output logic      [1:0]  sofStart
);

  typedef struct packed {
    logic [5:0]       sync1;
    logic [5:0]       sync2;
    logic [5:0]       prev;
    logic [1:0][15:0] ien;
    logic [1:0][15:0] flags;
    logic [1:0][13:0] period;
    logic [15:0]      cpuRdata;
    logic             cpuAck;
    logic [15:0]      hpiRdata;
    logic             hpiAck;
    logic [1:0]       irq;
  } top_state_t;

  localparam logic [1:0][15:0] FLAG_MASK = {H2_FLAG_MASK, H1_FLAG_MASK};

  top_state_t       stateReg;
  top_state_t       stateNext;
  logic [5:0]       pinsRaw;
  logic [5:0]       edges;
  decode_t          cpuDec;
  decode_t          hpiDec;
  decode_t          accDec;
  logic             cpuReq;
  logic             hpiReq;
  logic             wrEn;
  logic [15:0]      wrData;
  logic [1:0][15:0] clr;
  logic [1:0][15:0] set;
  logic [1:0]       frameClear;
  logic [1:0][13:0] liveCount;
  logic [1:0][10:0] frameNum;
  logic [1:0]       sofPulse;

  assign pinsRaw = {se0Line, otgId, vbusValid};

  function automatic logic [15:0] statusView(input logic h);
    logic [15:0] v;
    v = stateReg.flags[h];
    v[BIT_SE0_A] = stateReg.sync2[SYNC_SE0_BASE + 2 * h]; // see R08
    v[BIT_SE0_B] = stateReg.sync2[SYNC_SE0_BASE + 2 * h + 1]; // see R08
    return v;
  endfunction

  function automatic logic [15:0] readReg(input decode_t d);
    logic [15:0] v;
    v = 16'h0000;
    if (d.hit) begin
      case (d.sel)
        SEL_IEN:  v = stateReg.ien[d.host];
        SEL_STAT: v = statusView(d.host); // see R02
        SEL_PER:  v = {2'b00, stateReg.period[d.host]}; // see R13
        SEL_LIVE: v = {2'b00, liveCount[d.host]}; // see R15
        SEL_FRM:  v = {5'b00000, frameNum[d.host]}; // see R17
        default:  v = 16'h0000;
      endcase
    end
    return v;
  endfunction

  always_comb begin
    stateNext = stateReg;
    // Pins cross in through two flops before any logic looks at them
    stateNext.sync1 = pinsRaw;
    stateNext.sync2 = stateReg.sync1;
    stateNext.prev  = stateReg.sync2;
    edges = stateReg.sync2 ^ stateReg.prev;

    // The processor wins a same-cycle collision; the host port access is dropped and gets no ack
    cpuDec = decodeAddr(cpuAddr);
    hpiDec = decodeAddr(hpiAddr);
    cpuReq = cpuWr | cpuRd;
    hpiReq = (hpiWr | hpiRd) & ~cpuReq; // see R02
    stateNext.cpuAck = cpuReq;
    stateNext.hpiAck = hpiReq;
    if (cpuRd) begin
      stateNext.cpuRdata = readReg(cpuDec);
    end
    if (hpiReq && hpiRd) begin
      stateNext.hpiRdata = readReg(hpiDec); // see R02
    end
    accDec = cpuReq ? cpuDec : hpiDec;
    wrEn   = cpuReq ? cpuWr : (hpiReq & hpiWr);
    wrData = cpuReq ? cpuWdata : hpiWdata;

    for (int h = 0; h < 2; h++) begin
      clr[h] = 16'h0000;
      set[h] = 16'h0000;
      frameClear[h] = 1'b0;
      if (wrEn && accDec.hit && accDec.host == h[0]) begin
        case (accDec.sel)
          SEL_IEN: begin
            stateNext.ien[h] = wrData & FLAG_MASK[h];
          end
          SEL_STAT: begin
            clr[h] = wrData & FLAG_MASK[h]; // see R01
          end
          SEL_PER: begin
            // Upper two bits are dropped; software keeps them zero
            stateNext.period[h] = wrData[13:0]; // see R14
            frameClear[h] = 1'b1; // see R18
          end
          default: begin
            clr[h] = 16'h0000;
          end
        endcase
      end
      set[h][BIT_SOF]    = sofPulse[h]; // see R05
      set[h][BIT_WAKE_A] = remoteWake[2 * h]; // see R06
      set[h][BIT_WAKE_B] = remoteWake[2 * h + 1]; // see R06
      set[h][BIT_CONN_A] = edges[SYNC_SE0_BASE + 2 * h]; // see R07
      set[h][BIT_CONN_B] = edges[SYNC_SE0_BASE + 2 * h + 1]; // see R07
      set[h][BIT_DONE]   = transferDone[h]; // see R09
      if (h == 0) begin
        set[h][BIT_VBUS] = edges[SYNC_VBUS]; // see R03
        set[h][BIT_ID]   = edges[SYNC_ID]; // see R04
      end
      // A new event beats a clear arriving in the same cycle
      stateNext.flags[h] = ((stateReg.flags[h] & ~clr[h]) | set[h]) & FLAG_MASK[h]; // see R20
      stateNext.irq[h] = |(stateNext.flags[h] & stateReg.ien[h]); // see R19
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stateReg <= '{
        sync1:    6'h00,
        sync2:    6'h00,
        prev:     6'h00,
        ien:      32'h0000_0000,
        flags:    32'h0000_0000,
        period:   {PERIOD_RESET, PERIOD_RESET},
        cpuRdata: 16'h0000,
        cpuAck:   1'b0,
        hpiRdata: 16'h0000,
        hpiAck:   1'b0,
        irq:      2'b00
      }; // see R11
    end else begin
      stateReg <= stateNext;
    end
  end

  frame_timer_if ftIf[2] ();

  for (genvar g = 0; g < 2; g++) begin : gHost
    assign ftIf[g].periodCount = stateReg.period[g];
    assign ftIf[g].frameClear  = frameClear[g];
    assign liveCount[g]        = ftIf[g].liveCount;
    assign frameNum[g]         = ftIf[g].frameNum;
    assign sofPulse[g]         = ftIf[g].sofPulse;
    assign sofStart[g]         = ftIf[g].sofPulse; // see R21
    frame_timer uTimer (
      .clk   (clk),
      .rst_b (rst_b),
      .ft    (ftIf[g])
    );
  end

  assign cpuRdata = stateReg.cpuRdata;
  assign cpuAck   = stateReg.cpuAck;
  assign hpiRdata = stateReg.hpiRdata;
  assign hpiAck   = stateReg.hpiAck;
  assign hostIrq  = stateReg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_w1c_clear: assert property ( // see R01
    (clr[0][BIT_DONE] && !set[0][BIT_DONE]) |=> !stateReg.flags[0][BIT_DONE])
    else $error("one-write did not clear done flag");
  a_flag_sticky: assert property ( // see R20
    (stateReg.flags[1][BIT_WAKE_A] && !clr[1][BIT_WAKE_A]) |=> stateReg.flags[1][BIT_WAKE_A])
    else $error("flag dropped without a clear");
  a_set_wins: assert property ( // see R09
    transferDone[1] |=> stateReg.flags[1][BIT_DONE])
    else $error("done event lost");
  a_vbus_edge: assert property ( // see R03
    $changed(vbusValid) ##3 1'b1 |-> stateReg.flags[0][BIT_VBUS] || $past(clr[0][BIT_VBUS]))
    else $error("vbus edge not flagged");
  a_host2_reserved: assert property ( // see R04
    stateReg.flags[1][BIT_VBUS] == 1'b0 && stateReg.flags[1][BIT_ID] == 1'b0)
    else $error("host 2 otg bits set");
  a_sof_flag: assert property ( // see R05
    sofPulse[0] |=> stateReg.flags[0][BIT_SOF])
    else $error("frame timer expiry not flagged");
  a_conn_edge: assert property ( // see R07
    $rose(stateReg.sync2[SYNC_SE0_BASE]) |=> stateReg.flags[0][BIT_CONN_A])
    else $error("se0 edge not flagged");
  a_irq_mask: assert property ( // see R19
    !(|(stateReg.flags[0] & stateReg.ien[0])) ##1 !(|(stateReg.flags[0] & stateReg.ien[0]))
      |-> !hostIrq[0])
    else $error("masked flag raised interrupt");
  a_hpi_ack: assert property ( // see R02
    ((hpiWr || hpiRd) && !cpuWr && !cpuRd) |=> hpiAck)
    else $error("host port access not acknowledged");
  a_period_read: assert property ( // see R13
    (cpuRd && cpuAddr == H2_PER_ADDR) |=> cpuRdata == {2'b00, $past(stateReg.period[1])})
    else $error("count read not reload value");
  a_se0_live: assert property ( // see R08
    (cpuRd && cpuAddr == H1_STAT_ADDR) |=> cpuRdata[BIT_SE0_A] == $past(stateReg.sync2[2]))
    else $error("se0 status not live");

  c_sof_irq: cover property (sofPulse[0] ##1 hostIrq[0]);
  c_collision: cover property (cpuWr && hpiWr ##1 !cpuReq && hpiReq);
  c_set_clear: cover property (clr[0][BIT_DONE] && set[0][BIT_DONE]);
endmodule

// *** include/usb_host_pkg.sv ***
// Functional notes
// R01 - Writing a one to a status flag bit clears that pending flag.
// R02 - Status register is read and written from both the host port and the processor.
// R03 - Bit 15 sets on each bus-supply valid edge; host 1 only, reserved in host 2.
// R04 - Bit 14 sets on each OTG identification pin edge; host 1 only.
// R05 - Bit 9 sets whenever the frame down counter expires.
// R06 - Bits 7 and 6 set on remote wakeup at port B and port A.
// R07 - Bits 5 and 4 set on start or end of SE0 at port B and A.
// R08 - Bits 3 and 2 show live SE0 state of port B and port A.
// R09 - Bit 0 sets when a transfer completes; shared by both ports.
// R10 - Frame down counter reloads the programmed 14-bit count each time it reaches zero.
// R11 - Programmed count resets to 0x2EE0, a 1 ms frame.
// R12 - Frame counter counts down once per 12 MHz timebase tick.
// R13 - Reading the count register returns the programmed reload value.
// R14 - Software writes zeros to the two reserved upper count bits.
// R15 - A read-only register shows the live 14-bit down-counter value.
// R16 - Host 2 count, live counter and frame registers sit at 0xC0B2, 0xC0B4, 0xC0B6.
// R17 - Frame register holds next frame number, advancing after each start-of-frame.
// R18 - Frame number returns to zero after each write to the count register.
// R19 - A flag raises the interrupt only while its enable bit is one.
// R20 - Flags stay set until a one is written; zero writes leave them alone.
// R21 - Start-of-frame begins in the same cycle the frame-timer flag is raised; here sofStart rises one cycle before bit 9 is set.
package usb_host_pkg;

  localparam int CLK_HZ       = 10_000_000;
  localparam int TIMEBASE_HZ  = 12_000_000;
  localparam int TICK_UNIT_HZ = 1_000_000;
  // Fractional step: one tick every clock plus an extra one on accumulator wrap
  localparam logic [3:0] TICK_MOD   = 4'(CLK_HZ / TICK_UNIT_HZ);
  localparam logic [3:0] TICK_EXTRA = 4'((TIMEBASE_HZ - CLK_HZ) / TICK_UNIT_HZ);

  localparam int          FRAME_TIME_US = 1000;
  localparam logic [13:0] PERIOD_RESET  = 14'h2ee0;
  localparam logic [10:0] FRAME_RESET   = 11'h000;

  localparam logic [15:0] H1_IEN_ADDR  = 16'hc08c;
  localparam logic [15:0] H1_STAT_ADDR = 16'hc090;
  localparam logic [15:0] H1_PER_ADDR  = 16'hc092;
  localparam logic [15:0] H1_LIVE_ADDR = 16'hc094;
  localparam logic [15:0] H1_FRM_ADDR  = 16'hc096;
  localparam logic [15:0] H2_IEN_ADDR  = 16'hc0ac;
  localparam logic [15:0] H2_STAT_ADDR = 16'hc0b0;
  localparam logic [15:0] H2_PER_ADDR  = 16'hc0b2;
  localparam logic [15:0] H2_LIVE_ADDR = 16'hc0b4;
  localparam logic [15:0] H2_FRM_ADDR  = 16'hc0b6;

  localparam int BIT_VBUS   = 15;
  localparam int BIT_ID     = 14;
  localparam int BIT_SOF    = 9;
  localparam int BIT_WAKE_B = 7;
  localparam int BIT_WAKE_A = 6;
  localparam int BIT_CONN_B = 5;
  localparam int BIT_CONN_A = 4;
  localparam int BIT_SE0_B  = 3;
  localparam int BIT_SE0_A  = 2;
  localparam int BIT_DONE   = 0;

  localparam logic [15:0] H1_FLAG_MASK = 16'hc2f1;
  localparam logic [15:0] H2_FLAG_MASK = 16'h02f1;

  localparam int SYNC_VBUS     = 0;
  localparam int SYNC_ID       = 1;
  localparam int SYNC_SE0_BASE = 2;

  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_IEN  = 3'h1;
  localparam logic [2:0] SEL_STAT = 3'h2;
  localparam logic [2:0] SEL_PER  = 3'h3;
  localparam logic [2:0] SEL_LIVE = 3'h4;
  localparam logic [2:0] SEL_FRM  = 3'h5;

  typedef struct packed {
    logic       hit;
    logic       host;
    logic [2:0] sel;
  } decode_t;

  function automatic decode_t decodeAddr(input logic [15:0] a);
    decode_t d;
    d = '0;
    case (a)
      H1_IEN_ADDR:  d = '{1'b1, 1'b0, SEL_IEN};
      H1_STAT_ADDR: d = '{1'b1, 1'b0, SEL_STAT};
      H1_PER_ADDR:  d = '{1'b1, 1'b0, SEL_PER};
      H1_LIVE_ADDR: d = '{1'b1, 1'b0, SEL_LIVE};
      H1_FRM_ADDR:  d = '{1'b1, 1'b0, SEL_FRM};
      H2_IEN_ADDR:  d = '{1'b1, 1'b1, SEL_IEN};
      H2_STAT_ADDR: d = '{1'b1, 1'b1, SEL_STAT};
      H2_PER_ADDR:  d = '{1'b1, 1'b1, SEL_PER};
      H2_LIVE_ADDR: d = '{1'b1, 1'b1, SEL_LIVE};
      H2_FRM_ADDR:  d = '{1'b1, 1'b1, SEL_FRM};
      default:      d = '0;
    endcase
    return d;
  endfunction

endpackage

// *** include/frame_timer_if.sv ***
`timescale 1ns/1ns
interface frame_timer_if;
  logic [13:0] periodCount;
  logic        frameClear;
  logic [13:0] liveCount;
  logic [10:0] frameNum;
  logic        sofPulse;

  modport timer (
    input  periodCount,
    input  frameClear,
    output liveCount,
    output frameNum,
    output sofPulse
  );

  modport owner (
    output periodCount,
    output frameClear,
    input  liveCount,
    input  frameNum,
    input  sofPulse
  );
endinterface

// *** hw/frame_timer.sv ***
`timescale 1ns/1ns
module frame_timer
  import usb_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Owner side
  frame_timer_if.timer ft
);

  typedef struct packed {
    logic [3:0]  acc;
    logic [13:0] count;
    logic [10:0] frame;
    logic        sof;
  } timer_state_t;

  timer_state_t stateReg;
  timer_state_t stateNext;
  logic         extraTick;
  logic         exp1;
  logic         exp2;
  logic [13:0]  cnt1;
  logic [13:0]  cnt2;

  // One timebase tick: zero reloads and reports expiry
  function automatic logic [14:0] stepCount(input logic [13:0] cnt, input logic [13:0] per);
    if (cnt == 14'h0000) begin
      return {1'b1, per}; // see R10
    end
    return {1'b0, cnt - 14'h0001}; // see R12
  endfunction

  always_comb begin
    stateNext = stateReg;
    extraTick = (stateReg.acc + TICK_EXTRA) >= TICK_MOD; // see R12
    if (extraTick) begin
      stateNext.acc = stateReg.acc + TICK_EXTRA - TICK_MOD;
    end else begin
      stateNext.acc = stateReg.acc + TICK_EXTRA;
    end
    {exp1, cnt1} = stepCount(stateReg.count, ft.periodCount);
    if (extraTick) begin
      {exp2, cnt2} = stepCount(cnt1, ft.periodCount);
    end else begin
      exp2 = 1'b0;
      cnt2 = cnt1;
    end
    stateNext.count = cnt2;
    stateNext.sof   = exp1 | exp2; // see R21
    // A clear in the same cycle as a frame start wins; the next frame is then 0
    if (ft.frameClear) begin
      stateNext.frame = FRAME_RESET; // see R18
    end else if (exp1 | exp2) begin
      stateNext.frame = stateReg.frame + 11'h001; // see R17
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stateReg <= '{acc: 4'h0, count: PERIOD_RESET, frame: FRAME_RESET, sof: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign ft.liveCount = stateReg.count;
  assign ft.frameNum  = stateReg.frame;
  assign ft.sofPulse  = stateReg.sof;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_count_reload: assert property ( // see R10
    (stateReg.count == 14'h0000 && !extraTick) |=> stateReg.count == $past(ft.periodCount))
    else $error("counter did not reload at zero");
  a_count_down: assert property ( // see R12
    (stateReg.count > 14'h0002) |=> (stateReg.count < $past(stateReg.count)))
    else $error("counter did not decrement");
  a_frame_advance: assert property ( // see R17
    (stateNext.sof && !ft.frameClear) |=> stateReg.frame == $past(stateReg.frame) + 11'h001)
    else $error("frame number did not advance");
  a_frame_clear: assert property ( // see R18
    ft.frameClear |=> stateReg.frame == 11'h000)
    else $error("frame number not cleared");
  c_double_tick: cover property (extraTick && exp2);
endmodule

// *** test/usb_port_model.sv ***
`timescale 1ns/1ns
module usb_port_model (
  // Clock
  input  wire logic       clk,
  // Line state and serial engine events
  output logic      [3:0] se0Line,
  output logic      [3:0] remoteWake,
  output logic      [1:0] transferDone
);
  // Devices start attached and idle, so no SE0 and no connect event at release
  initial begin
    se0Line = 4'h0;
    remoteWake = 4'h0;
    transferDone = 2'h0;
  end

  // Events are single-cycle pulses launched off the falling edge
  task automatic wake(input int idx);
    @(negedge clk) remoteWake[idx] = 1'b1;
    @(negedge clk) remoteWake[idx] = 1'b0;
  endtask

  task automatic done(input int idx);
    @(negedge clk) transferDone[idx] = 1'b1;
    @(negedge clk) transferDone[idx] = 1'b0;
  endtask

  // Attach or detach: SE0 held until the next call
  task automatic line(input int idx, input logic v);
    @(negedge clk) se0Line[idx] = v;
  endtask
endmodule

// *** test/test_usb_host_status_frame_timer.sv ***
`timescale 1ns/1ns
module test_usb_host_status_frame_timer;
  logic        clk;
  logic        rst_b;
  logic [15:0] busAddr;
  logic [15:0] busWdata;
  logic [15:0] hostAddr;
  logic [15:0] hostWdata;
  logic        cpuWr;
  logic        cpuRd;
  logic        hpiWr;
  logic        hpiRd;
  logic [15:0] cpuRdata;
  logic [15:0] hpiRdata;
  logic        cpuAck;
  logic        hpiAck;
  logic        vbusValid;
  logic        otgId;
  logic [3:0]  se0Line;
  logic [3:0]  remoteWake;
  logic [1:0]  transferDone;
  logic [1:0]  hostIrq;
  logic [1:0]  sofStart;
  int          failCount;
  int          testsRun;

  // Each port has its own address and data; only one strobe is raised at a time
  usb_host_status_frame_timer usb_host_status_frame_timer_inst (
    .clk(clk), .rst_b(rst_b),
    .cpuAddr(busAddr), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuWdata(busWdata),
    .cpuRdata(cpuRdata), .cpuAck(cpuAck),
    .hpiAddr(hostAddr), .hpiWr(hpiWr), .hpiRd(hpiRd), .hpiWdata(hostWdata),
    .hpiRdata(hpiRdata), .hpiAck(hpiAck),
    .vbusValid(vbusValid), .otgId(otgId), .se0Line(se0Line),
    .remoteWake(remoteWake), .transferDone(transferDone),
    .hostIrq(hostIrq), .sofStart(sofStart)
  );

  usb_port_model usb_port_model_inst (
    .clk(clk), .se0Line(se0Line), .remoteWake(remoteWake),
    .transferDone(transferDone)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic closeOut;
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One access on either port; ack is registered on the taking edge and checked half a cycle later
  task automatic acc(input bit p, input bit w, input logic [15:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    busAddr = p ? 16'h0000 : a;
    busWdata = p ? 16'h0000 : d;
    hostAddr = p ? a : 16'h0000;
    hostWdata = p ? d : 16'h0000;
    {hpiWr, hpiRd, cpuWr, cpuRd} = p ? {w, !w, 2'b00} : {2'b00, w, !w};
    @(negedge clk);
    {hpiWr, hpiRd, cpuWr, cpuRd} = 4'h0;
    chk(16'(p ? hpiAck : cpuAck), 16'h0001);
    q = p ? hpiRdata : cpuRdata;
  endtask

  task automatic wr(input bit p, input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    acc(p, 1'b1, a, d, q);
  endtask

  task automatic rd(input bit p, input logic [15:0] a, input logic [15:0] e);
    logic [15:0] q;
    acc(p, 1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask

  task automatic settle;
    repeat (5) @(negedge clk);
  endtask

  task automatic testResetValues;
    rd(0, 16'hc092, 16'h2ee0);
    rd(1, 16'hc0b2, 16'h2ee0);
    rd(0, 16'hc096, 16'h0000);
    rd(0, 16'hc090, 16'h0000);
    rd(0, 16'hc098, 16'h0000);
  endtask

  task automatic testWakeDone;
    usb_port_model_inst.wake(0);
    usb_port_model_inst.wake(1);
    usb_port_model_inst.done(0);
    rd(1, 16'hc090, 16'h00c1);
    wr(1, 16'hc090, 16'h0040);
    rd(1, 16'hc090, 16'h0081);
    wr(0, 16'hc090, 16'h0000);
    rd(0, 16'hc090, 16'h0081);
    wr(0, 16'hc090, 16'h0081);
    rd(0, 16'hc090, 16'h0000);
    usb_port_model_inst.wake(3);
    usb_port_model_inst.done(1);
    rd(1, 16'hc0b0, 16'h0081);
    wr(1, 16'hc0b0, 16'h0081);
  endtask

  task automatic testSe0;
    usb_port_model_inst.line(1, 1'b1);
    settle();
    rd(0, 16'hc090, 16'h0028);
    wr(0, 16'hc090, 16'h0028);
    rd(0, 16'hc090, 16'h0008);
    usb_port_model_inst.line(1, 1'b0);
    settle();
    rd(0, 16'hc090, 16'h0020);
    wr(0, 16'hc090, 16'h0020);
  endtask

  task automatic testOtg;
    vbusValid = 1'b1;
    settle();
    rd(0, 16'hc090, 16'h8000);
    rd(0, 16'hc0b0, 16'h0000);
    wr(0, 16'hc090, 16'h8000);
    vbusValid = 1'b0;
    settle();
    rd(0, 16'hc090, 16'h8000);
    wr(0, 16'hc090, 16'h8000);
    otgId = 1'b1;
    settle();
    rd(1, 16'hc090, 16'h4000);
    wr(1, 16'hc090, 16'h4000);
  endtask

  task automatic testIrq;
    usb_port_model_inst.done(0);
    chk(16'(hostIrq), 16'h0000);
    wr(0, 16'hc08c, 16'h0001);
    repeat (2) @(negedge clk);
    chk(16'(hostIrq), 16'h0001);
    wr(0, 16'hc090, 16'h0001);
    repeat (2) @(negedge clk);
    chk(16'(hostIrq), 16'h0000);
    wr(0, 16'hc08c, 16'h0000);
  endtask

  // Counts falling edges until the next host 1 start-of-frame pulse
  task automatic waitSof(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sofStart[0] !== 1'b1 && n < 13000);
    chk(16'(n < 13000), 16'h0001);
  endtask

  task automatic testTimer;
    int n;
    logic [15:0] q;
    wr(0, 16'hc092, 16'h0010);
    rd(0, 16'hc096, 16'h0000);
    waitSof(n);
    rd(0, 16'hc090, 16'h0200);
    rd(0, 16'hc096, 16'h0001);
    wr(0, 16'hc090, 16'h0200);
    // Resynchronise on a pulse so the next wait spans one whole short frame
    waitSof(n);
    waitSof(n);
    // Seventeen ticks at twelve per ten clocks
    chk(16'(n >= 14 && n <= 15), 16'h0001);
    rd(0, 16'hc096, 16'h0003);
    rd(0, 16'hc092, 16'h0010);
    acc(0, 1'b0, 16'hc094, 16'h0000, q);
    chk(16'(q <= 16'h0010), 16'h0001);
  endtask

  task automatic testHost2;
    wr(1, 16'hc0b2, 16'h0020);
    rd(1, 16'hc0b2, 16'h0020);
    rd(0, 16'hc0b6, 16'h0000);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    closeOut();
  end

  initial begin
    failCount = 0;
    testsRun = 0;
    rst_b = 1'b0;
    busAddr = 16'h0000;
    busWdata = 16'h0000;
    hostAddr = 16'h0000;
    hostWdata = 16'h0000;
    {hpiWr, hpiRd, cpuWr, cpuRd} = 4'h0;
    vbusValid = 1'b0;
    otgId = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    settle();
    testResetValues();
    testWakeDone();
    testSe0();
    testOtg();
    testIrq();
    testTimer();
    testHost2();
    closeOut();
  end
endmodule
